// ==== core/txcr_pkg.sv ====
package txcr_pkg;

    // ******************************************************
    // register map and field layout
    // ******************************************************
    localparam logic [3:0] TXCR_REG_LOW_NIBBLE   = 4'h4;  // low nibble of every channel's address
    localparam logic [7:0] TXCR_RESET_VALUE      = 8'h00;
    localparam logic [7:0] TXCR_WRITE_MASK       = 8'h37; // bits 7, 6 and 3 are not stored
    localparam int         TXCR_BIT_DRV_MON_INT  = 5;
    localparam int         TXCR_BIT_ERR_INSERT   = 4;
    localparam int         TXCR_BIT_ALL_ONES     = 2;
    localparam int         TXCR_BIT_EDGE_SELECT  = 1;
    localparam int         TXCR_BIT_BUILDOUT     = 0;

    // ******************************************************
    // timing
    // ******************************************************
    localparam int         TXCR_DMO_BIT_PERIODS  = 128;   // silent bit periods before alarm
    localparam int         TXCR_SYNC_STAGES      = 2;

    // ******************************************************
    // carriers
    // ******************************************************
    typedef struct packed {
        logic       rsvd_7;
        logic       rsvd_6;
        logic       drv_mon_internal;
        logic       err_insert;
        logic       rsvd_3;
        logic       send_all_ones;
        logic       tx_sample_edge_select;
        logic       line_buildout_select;
    } txcr_ctrl_t;

    typedef struct packed {
        logic       sel;    // chip select, one cycle with rd or wr
        logic       wr;     // write strobe
        logic       rd;     // read strobe
        logic [7:0] addr;
        logic [7:0] wdata;
    } txcr_cpu_req_t;

    // high nibble of address per channel: 0-5 then 8-D
    function automatic logic [3:0] txcr_chan_nibble(input int chan);
        logic [3:0] n;
        n = (chan < 6) ? 4'(chan) : 4'(chan + 2);
        return n;
    endfunction

endpackage

// ==== core/txcr_channel.sv ====
`timescale 1ns/10ps
// Functional notes
// [RULE_01] bit 5: 1 internal pad monitor, 0 monitor pins
// [RULE_02] 0-to-1 write of bit 4 corrupts one bit
// [RULE_03] error insert needs generator and receiver enabled
// [RULE_04] host must clear bit 4 before next insert
// [RULE_05] address 0xM4, M is 0-5 or 8-D
// [RULE_06] bits 7, 6, 3 read zero, writes ignored
// [RULE_07] alarm after 128 silent bit periods, clears on pulse
// [RULE_08] bit 2 replaces system data with all ones
// [RULE_09] bit 1 picks transmit clock sampling edge
// [RULE_10] bit 0 build-out, ignored in E3 mode
module txcr_channel
    import txcr_pkg::*;
#(
    parameter int CHAN_INDEX = 0
) (
    input  wire logic          clk_sys,                // 200 MHz register clock
    input  wire logic          reset_n,                // async reset, active low
    input  wire txcr_cpu_req_t cpu_req,                // host access request
    output logic [7:0]         cpu_rdata,              // read data, registered
    output logic               cpu_ack,                // access answered, one cycle
    input  wire logic          bit_tick,               // one pulse per line bit period
    input  wire logic          tx_pos_data_in,         // system positive data
    input  wire logic          tx_neg_data_in,         // system negative data
    input  wire logic          tx_line_pos_out,        // observed level of positive pad
    input  wire logic          tx_line_neg_out,        // observed level of negative pad
    input  wire logic          monitor_pos_in,         // external monitor pin, positive
    input  wire logic          monitor_neg_in,         // external monitor pin, negative
    input  wire logic          prbs_gen_enable,        // pattern generator enabled
    input  wire logic          prbs_rx_enable,         // pattern receiver enabled
    input  wire logic          e3_mode,                // channel runs at E3 rate
    output logic               prbs_error_insert,      // one-cycle error request
    output logic               tx_line_pos_data,       // positive data to line, registered
    output logic               tx_line_neg_data,       // negative data to line, registered
    output logic               tx_sample_edge_select,  // 1 rising, 0 falling edge
    output logic               line_buildout_select,   // build-out enable to driver
    output logic               drive_monitor_alarm     // no pulses for 128 periods
);

    // ******************************************************
    // address decode and write data
    // ******************************************************
    localparam logic [7:0] REG_ADDR = {txcr_chan_nibble(CHAN_INDEX), TXCR_REG_LOW_NIBBLE};

    txcr_ctrl_t ctrl_q;
    txcr_ctrl_t ctrl_d;
    txcr_ctrl_t ctrl_rd;
    logic [7:0] rdata_q;
    logic       ack_q;
    logic       err_pulse_q;
    wire        addr_hit;
    wire        wr_hit;
    wire        rd_hit;
    wire        err_edge;
    wire        err_enabled;

    // decode the one channel address
    assign addr_hit    = cpu_req.sel && (cpu_req.addr == REG_ADDR);  // RULE_05
    assign wr_hit      = addr_hit && cpu_req.wr;
    assign rd_hit      = addr_hit && cpu_req.rd;
    assign ctrl_d      = wr_hit ? txcr_ctrl_t'(cpu_req.wdata & TXCR_WRITE_MASK) : ctrl_q;  // RULE_06
    assign ctrl_rd     = txcr_ctrl_t'(8'(ctrl_q) & TXCR_WRITE_MASK);                       // RULE_06
    // fresh rising edge only: a held 1 gives nothing more
    assign err_edge    = wr_hit && cpu_req.wdata[TXCR_BIT_ERR_INSERT] && !ctrl_q.err_insert;  // RULE_02 RULE_04
    assign err_enabled = prbs_gen_enable && prbs_rx_enable;                                   // RULE_03

    // control register and error pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q      <= txcr_ctrl_t'(TXCR_RESET_VALUE);
            err_pulse_q <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            err_pulse_q <= err_edge && err_enabled;  // RULE_02 RULE_03
        end
    end

    // read answer; other addresses of the bus read zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            ack_q   <= 1'b0;
        end else begin
            rdata_q <= rd_hit ? 8'(ctrl_rd) : 8'h00;
            ack_q   <= wr_hit || rd_hit;
        end
    end

    // ******************************************************
    // pin synchronisers
    // ******************************************************
    wire  [3:0] pin_raw = {monitor_neg_in, monitor_pos_in, tx_line_neg_out, tx_line_pos_out};
    wire  [3:0] pin_s2_q;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            logic s1_q;  // first stage, read only by the second
            logic s2_q;  // second stage, safe to use
            // two flops per pin, both stages in one shared process
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                end
            end
            assign pin_s2_q[gi] = s2_q;
        end
    endgenerate

    // ******************************************************
    // drive monitor
    // ******************************************************
    localparam logic [7:0] SILENT_LIMIT = 8'(TXCR_DMO_BIT_PERIODS);

    logic [7:0] silent_cnt_q;
    logic       pulse_hold_q;
    logic       alarm_q;
    wire        pulse_now;
    wire        pulse_in_period;
    wire  [7:0] silent_cnt_inc;

    // source choice: internal pads or external monitor pins
    assign pulse_now       = ctrl_q.drv_mon_internal ? (pin_s2_q[0] || pin_s2_q[1])   // RULE_01
                                                     : (pin_s2_q[2] || pin_s2_q[3]);  // RULE_01
    assign pulse_in_period = pulse_hold_q || pulse_now;
    assign silent_cnt_inc  = silent_cnt_q + 8'h01;

    // pulse latch per bit period
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pulse_hold_q <= 1'b0;
        end else begin
            pulse_hold_q <= bit_tick ? 1'b0 : pulse_in_period;
        end
    end

    // count silent periods, saturate at limit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            silent_cnt_q <= 8'h00;
            alarm_q      <= 1'b0;
        end else if (bit_tick) begin
            if (pulse_in_period) begin
                silent_cnt_q <= 8'h00;  // RULE_07
                alarm_q      <= 1'b0;   // RULE_07
            end else if (silent_cnt_q != SILENT_LIMIT) begin
                silent_cnt_q <= silent_cnt_inc;
                alarm_q      <= (silent_cnt_inc == SILENT_LIMIT);  // RULE_07
            end
        end
    end

    // ******************************************************
    // transmit data path
    // ******************************************************
    logic line_pos_q;
    logic line_neg_q;

    // all ones replaces system data, one register per bit period
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            line_pos_q <= 1'b0;
            line_neg_q <= 1'b0;
        end else if (bit_tick) begin
            line_pos_q <= ctrl_q.send_all_ones ? 1'b1 : tx_pos_data_in;  // RULE_08
            line_neg_q <= ctrl_q.send_all_ones ? 1'b0 : tx_neg_data_in;  // RULE_08
        end
    end

    // outputs
    assign cpu_rdata             = rdata_q;
    assign cpu_ack               = ack_q;
    assign prbs_error_insert     = err_pulse_q;
    assign tx_line_pos_data      = line_pos_q;
    assign tx_line_neg_data      = line_neg_q;
    assign tx_sample_edge_select = ctrl_q.tx_sample_edge_select;                // RULE_09
    assign line_buildout_select  = ctrl_q.line_buildout_select && !e3_mode;    // RULE_10
    assign drive_monitor_alarm   = alarm_q;

    // ******************************************************
    // assertions
    // ******************************************************
    sequence s_fresh_insert;
        wr_hit && cpu_req.wdata[TXCR_BIT_ERR_INSERT] && !ctrl_q.err_insert && err_enabled;
    endsequence

    sequence s_reg_write;
        wr_hit;
    endsequence

    sequence s_reg_read;
        rd_hit;
    endsequence

    a_err_edge_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_02
        s_fresh_insert |=> prbs_error_insert ##1 !prbs_error_insert)
        else $error("error insert edge did not give one pulse");

    a_err_level_held: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_04
        $past(ctrl_q.err_insert) && ctrl_q.err_insert |-> !prbs_error_insert)
        else $error("error insert fired on a held level");

    a_err_gated_off: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_03
        !err_enabled |=> !prbs_error_insert)
        else $error("error insert fired while pattern logic disabled");

    a_rsvd_read_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_06
        cpu_ack |-> (cpu_rdata[7:6] == 2'b00) && !cpu_rdata[3])
        else $error("reserved bits read nonzero");

    a_addr_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_05
        cpu_req.sel && cpu_req.wr && (cpu_req.addr != REG_ADDR) |=> $stable(ctrl_q))
        else $error("write to foreign address changed register");

    a_write_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_06
        s_reg_write ##1 !addr_hit ##1 s_reg_read
        |=> cpu_rdata == ($past(cpu_req.wdata, 3) & TXCR_WRITE_MASK))
        else $error("readback differs from written value");

    a_alarm_raise: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_07
        bit_tick && !pulse_in_period && silent_cnt_q == 8'h7F |=> drive_monitor_alarm)
        else $error("alarm not raised at 128 silent periods");

    a_alarm_early: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_07
        drive_monitor_alarm |-> silent_cnt_q == SILENT_LIMIT)
        else $error("alarm raised before 128 silent periods");

    a_alarm_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_07
        bit_tick && pulse_in_period |=> !drive_monitor_alarm)
        else $error("alarm not cleared after pulse");

    a_all_ones_out: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_08
        bit_tick && ctrl_q.send_all_ones |=> tx_line_pos_data && !tx_line_neg_data)
        else $error("all ones not sent");

    a_buildout_e3: assert property (@(posedge clk_sys) disable iff (!reset_n)  // RULE_10
        e3_mode |-> !line_buildout_select)
        else $error("build-out active in E3 mode");

endmodule

// ==== tb/txcr_host_model.sv ====
`timescale 1ns/10ps
// ****************************************
// host processor on the strobe register bus
// ****************************************
module txcr_host_model
    import txcr_pkg::*;
(
    input  wire logic       clk_sys,    // register clock
    output txcr_cpu_req_t   cpu_req,    // access request
    input  wire logic [7:0] cpu_rdata,  // read data
    input  wire logic       cpu_ack     // answer strobe
);
    logic [7:0] rd_q;   // data of last access
    logic       ack_q;  // answer of last access

    initial cpu_req = '0;

    // one access, request held for one edge, answer taken one cycle later
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk_sys);
        cpu_req <= '{sel: 1'b1, wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge clk_sys);
        // released bus shows inverted leftovers, not the last value
        cpu_req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        #1;
        ack_q = cpu_ack;
        rd_q  = cpu_rdata;
    endtask
endmodule

// ==== tb/tx_channel_control_register_bench.sv ====
`timescale 1ns/10ps
module tx_channel_control_register_bench
    import txcr_pkg::*;
;
    // ****************************************
    // stimulus, design and host
    // ****************************************
    localparam int CHAN = 7;
    logic          clk_sys, reset_n, bit_tick, dpos, dneg, pad_p, pad_n, mon_p, mon_n, gen_en, rx_en, e3;
    logic          cpu_ack, ins, lp, ln, edge_sel, bo, alarm;
    logic [7:0]    cpu_rdata;
    txcr_cpu_req_t cpu_req;
    int            n_fail = 0;
    int            checks_done = 0;
    int            n_ins = 0;
    logic [31:0]   seed = 32'h51;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_addr(input int c);
        return {(c < 6) ? 4'(c) : 4'(c + 2), 4'h4};
    endfunction

    localparam logic [7:0] REG = exp_addr(CHAN);

    txcr_channel #(.CHAN_INDEX(CHAN)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .bit_tick(bit_tick), .tx_pos_data_in(dpos),
        .tx_neg_data_in(dneg), .tx_line_pos_out(pad_p), .tx_line_neg_out(pad_n), .monitor_pos_in(mon_p),
        .monitor_neg_in(mon_n), .prbs_gen_enable(gen_en), .prbs_rx_enable(rx_en), .e3_mode(e3),
        .prbs_error_insert(ins), .tx_line_pos_data(lp), .tx_line_neg_data(ln),
        .tx_sample_edge_select(edge_sel), .line_buildout_select(bo), .drive_monitor_alarm(alarm));
    txcr_host_model host_u (.clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // counts error-insert pulses
    always @(posedge clk_sys) begin
        if (ins === 1'b1) n_ins <= n_ins + 1;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] d);
        host_u.access(1'b1, REG, d);
        check("write ack", 32'(host_u.ack_q), 1);
    endtask

    task automatic rd(input logic [7:0] exp, input string what);
        host_u.access(1'b0, REG, 8'h00);
        check("read ack", 32'(host_u.ack_q), 1);
        check(what, 32'(host_u.rd_q), 32'(exp));
    endtask

    task automatic tick(input logic p, input logic n);
        @(posedge clk_sys);
        bit_tick <= 1'b1;
        dpos     <= p;
        dneg     <= n;
        @(posedge clk_sys);
        bit_tick <= 1'b0;
    endtask

    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {bit_tick, dpos, dneg, pad_p, pad_n, mon_p, mon_n, gen_en, rx_en, e3} = '0;
        reset_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(8'h00, "reset value");
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            @(posedge clk_sys);
            gen_en <= seed[8];
            rx_en  <= seed[8] ? 1'b0 : seed[9];
            e3     <= seed[10];
            wr(seed[7:0]);
            rd(seed[7:0] & 8'h37, "readback");
            check("edge select", 32'(edge_sel), 32'(seed[1]));
            check("buildout", 32'(bo), 32'(seed[0] & !seed[10]));
        end
        @(posedge clk_sys);
        {gen_en, rx_en} <= 2'b00;
        wr(8'h15);
        for (int n = 0; n < 16; n++) begin
            if (n != 9) begin
                host_u.access(1'b1, 8'(n * 16 + 4), 8'h22);
                check("stray ack", 32'(host_u.ack_q), 0);
            end
        end
        host_u.access(1'b0, REG + 8'h01, 8'h00);
        check("stray read", 32'(host_u.rd_q), 0);
        rd(8'h15, "after stray writes");
        @(posedge clk_sys);
        gen_en <= 1'b1;
        wr(8'h00);
        wr(8'h10);
        settle();
        check("insert one enable", n_ins, 0);
        @(posedge clk_sys);
        rx_en <= 1'b1;
        wr(8'h00);
        wr(8'h10);
        wr(8'h10);
        settle();
        check("single insert", n_ins, 1);
        wr(8'h00);
        wr(8'h14);
        settle();
        check("second insert", n_ins, 2);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            if (i == 4) wr(8'h00);
            tick(seed[0], seed[1]);
            settle();
            check("line pos", 32'(lp), (i < 4) ? 1 : 32'(seed[0]));
            check("line neg", 32'(ln), (i < 4) ? 0 : 32'(seed[1]));
        end
        wr(8'h20);
        @(posedge clk_sys);
        pad_p <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tick(1'b0, 1'b0);
        @(posedge clk_sys);
        pad_p <= 1'b0;
        mon_p <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tick(1'b0, 1'b0);
        repeat (127) tick(1'b0, 1'b0);
        settle();
        check("alarm early", 32'(alarm), 0);
        tick(1'b0, 1'b0);
        settle();
        check("alarm raised", 32'(alarm), 1);
        wr(8'h00);
        repeat (4) @(posedge clk_sys);
        tick(1'b0, 1'b0);
        settle();
        check("alarm cleared", 32'(alarm), 0);
        @(posedge clk_sys);
        mon_p <= 1'b0;
        pad_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tick(1'b0, 1'b0);
        repeat (128) tick(1'b0, 1'b0);
        settle();
        check("pads ignored", 32'(alarm), 1);
        give_verdict();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        give_verdict();
    end
endmodule
